// ### hw/cpps_regs.vh
// Register map, field positions and encodings of the charger profile and pin status bank
`ifndef CPPS_REGS_VH
`define CPPS_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CPPS_ADDR_PROFILE_ONE    8'h12
`define CPPS_ADDR_LEGACY         8'h13
`define CPPS_ADDR_PIN_STATE      8'h14

// ****************************************************************
// Profile status one fields
// ****************************************************************
`define CPPS_P1_PASSTHRU         0
`define CPPS_P1_CDP              1
`define CPPS_P1_DCP              2
`define CPPS_P1_CUSTOM           3
`define CPPS_P1_UNDERVOLT        4
`define CPPS_P1_NO_HANDSHAKE     7

// ****************************************************************
// Pin status fields
// ****************************************************************
`define CPPS_PIN_STATE_LSB       0
`define CPPS_PIN_POLARITY        2
`define CPPS_PIN_EMUL            3
`define CPPS_PIN_MODE1           4
`define CPPS_PIN_MODE2           5
`define CPPS_PIN_PORT_POWER_ENABLE          6

// ****************************************************************
// Power state encodings, accepted profile codes, reset byte and limit mode encodings
// ****************************************************************
`define CPPS_STATE_SLEEP         2'h0
`define CPPS_STATE_DETECT        2'h1
`define CPPS_STATE_ACTIVE        2'h2
`define CPPS_STATE_ERROR         2'h3

`define CPPS_PROF_CDP            4'h1
`define CPPS_PROF_DCP            4'h2
`define CPPS_PROF_CUSTOM         4'h3
`define CPPS_PROF_LEGACY_BASE    4'h8
`define CPPS_RESET_BYTE          8'h00
`define CPPS_LIMIT_TRIP          2'h0
`define CPPS_LIMIT_CONSTANT      2'h1

`endif

// ### hw/cpps_sync.v
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/1ns
`default_nettype none

module cpps_sync
#(
    parameter WIDTH = 6
)
(
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rst_b,
    // Asynchronous levels in, synchronised levels out
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage_one;

    // First stage feeds only the second stage
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage_one <= {WIDTH{1'b0}};
            sync_out  <= {WIDTH{1'b0}};
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

`default_nettype wire

// ### hw/cpps_status.v
// Charger profile and pin status register bank of a USB port power controller
// Function
// - Set the CDP bit when the device completes a CDP handshake; close data switch, trip limit.
// - Hold the pass-through bit while in pass-through or SDP active mode, trip limit, else clear.
// - Set the no-handshake flag at the end of each profile the device did not handshake with.
// - The no-handshake flag is never set together with profile status bits 3..0 or a legacy bit; undervoltage can be.
// - After removal then attach in the same mode, pass-through stays clear until mode one toggles.
// - Profile bits drive the data switch and limit mode outputs and are read back at profile status one.
// - Profile bits clear on power enable off, new active mode, or removal detection.
// - Legacy register bit 7 reads zero; bits 6..0 flag legacy profiles seven..one.
// - A legacy profile uses the charger switch bit for the data switch and custom limiting.
// - Pin status bits 6..3 mirror effective power enable, mode two, mode one, emulation enable.
// - The polarity pin is caught once after power-up and shown at pin status bit 2.
// - Pin status bits 1..0 follow the power state: sleep, detect, active, error.
// - Any host access wakes the device, so a read never returns the sleep code.
// - Set the DCP bit when the device accepts DCP; constant-current limit, switch from config.
// - The undervoltage bit follows the source supply below threshold and clears above it.
`timescale 1ns/1ns
`default_nettype none
`include "cpps_regs.vh"

module cpps_status
(
    // Clock and reset
    input  wire       ref_clk,
    input  wire       rst_b,
    // External control pins, asynchronous
    input  wire       port_power_enable_pin,
    input  wire       mode_select_first_pin,
    input  wire       mode_select_second_pin,
    input  wire       emulation_enable_pin,
    input  wire       polarity_select_pin,
    input  wire       source_undervoltage_pin,
    // Register overrides from the configuration bank
    input  wire       override_enable,
    input  wire       port_power_enable_set,
    input  wire       mode_select_first_set,
    input  wire       mode_select_second_set,
    input  wire       emulation_enable_set,
    input  wire       dedicated_charger_switch_close,
    input  wire       custom_switch_close,
    input  wire [1:0] custom_limit_mode,
    // Emulation engine events, one-cycle pulses, plus pass-through mode and power state levels
    input  wire       passthrough_mode,
    input  wire       profile_accepted,
    input  wire [3:0] profile_code,
    input  wire       profile_ended_no_handshake,
    input  wire       profile_applied,
    input  wire       removal_event,
    input  wire       new_active_mode,
    input  wire [1:0] power_state,
    // Register read port
    input  wire       host_access,
    input  wire [7:0] read_addr,
    output reg  [7:0] read_data,
    output reg        wake_request,
    // Switch steering outputs
    output reg        data_switch_close,
    output reg  [1:0] limit_mode
);

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    wire [5:0] pin_sync;
    reg        pw_en_eff;
    reg        m1_eff;
    reg        m2_eff;
    reg        em_eff;
    reg        m1_prev;
    reg        polarity;
    reg        polarity_caught;
    reg  [1:0] settle;
    reg        pt_blocked;
    reg        pt_seen;
    reg  [7:0] profile_one;
    reg  [7:0] legacy;
    reg  [7:0] next_read_data;
    reg        next_switch;
    reg  [1:0] next_limit;
    wire       pw_en_raw;
    wire       clear_all;
    wire       m1_toggle;
    wire [6:0] legacy_hit;

    // Pins pass two flops before any logic reads them
    cpps_sync
    #(
        .WIDTH (6)
    )
    u_sync
    (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in ({source_undervoltage_pin, polarity_select_pin, emulation_enable_pin,
                    mode_select_second_pin, mode_select_first_pin, port_power_enable_pin}),
        .sync_out (pin_sync)
    );

    // Power enable pin decoded with the caught polarity
    assign pw_en_raw = polarity ? pin_sync[0] : ~pin_sync[0];

    // Effective controls, pin or register override
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pw_en_eff <= 1'b0;
            m1_eff    <= 1'b0;
            m2_eff    <= 1'b0;
            em_eff    <= 1'b0;
            m1_prev   <= 1'b0;
        end
        else
        begin
            pw_en_eff <= override_enable ? port_power_enable_set  : pw_en_raw;
            m1_eff    <= override_enable ? mode_select_first_set  : pin_sync[1];
            m2_eff    <= override_enable ? mode_select_second_set : pin_sync[2];
            em_eff    <= override_enable ? emulation_enable_set   : pin_sync[3];
            m1_prev   <= m1_eff;
        end
    end

    // Polarity caught once, after the synchroniser has filled with the pin
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            settle          <= 2'h0;
            polarity        <= 1'b1;
            polarity_caught <= 1'b0;
        end
        else
        begin
            settle <= {settle[0], 1'b1};
            if (settle[1] && !polarity_caught)
            begin
                polarity        <= pin_sync[4];
                polarity_caught <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Profile status
    // ****************************************************************
    // Power enable off, new mode or removal clears profile bits
    assign clear_all = ~pw_en_eff | new_active_mode | removal_event;
    assign m1_toggle = m1_eff ^ m1_prev;

    // Pass-through block after removal until mode one toggles
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pt_blocked <= 1'b0;
            pt_seen    <= 1'b0;
        end
        else
        begin
            if (removal_event && pt_seen && !new_active_mode)
            begin
                pt_blocked <= 1'b1;
            end
            else if (m1_toggle || new_active_mode)
            begin
                pt_blocked <= 1'b0;
                pt_seen    <= 1'b0;
            end
            else if (profile_one[`CPPS_P1_PASSTHRU])
            begin
                pt_seen <= 1'b1;
            end
        end
    end

    // Profile status one register
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            profile_one <= `CPPS_RESET_BYTE;
        end
        else
        begin
            profile_one[`CPPS_P1_UNDERVOLT] <= pin_sync[5];
            profile_one[6:5] <= 2'h0;
            if (clear_all)
            begin
                profile_one[`CPPS_P1_PASSTHRU] <= 1'b0;
                profile_one[`CPPS_P1_CDP]      <= 1'b0;
                profile_one[`CPPS_P1_DCP]      <= 1'b0;
                profile_one[`CPPS_P1_CUSTOM]   <= 1'b0;
                profile_one[`CPPS_P1_NO_HANDSHAKE] <= 1'b0;
            end
            else if (profile_accepted)
            begin
                // Acceptance clears the no-handshake flag
                profile_one[`CPPS_P1_NO_HANDSHAKE] <= 1'b0;
                if (profile_code == `CPPS_PROF_CDP)
                    profile_one[`CPPS_P1_CDP] <= 1'b1;
                if (profile_code == `CPPS_PROF_DCP)
                    profile_one[`CPPS_P1_DCP] <= 1'b1;
                if (profile_code == `CPPS_PROF_CUSTOM)
                    profile_one[`CPPS_P1_CUSTOM] <= 1'b1;
            end
            else
            begin
                profile_one[`CPPS_P1_PASSTHRU] <= passthrough_mode & ~pt_blocked;
                if (profile_ended_no_handshake && !(|profile_one[3:0]) && !(|legacy) &&
                    !(passthrough_mode && !pt_blocked))
                    profile_one[`CPPS_P1_NO_HANDSHAKE] <= 1'b1;
                else if (profile_applied || passthrough_mode)
                    profile_one[`CPPS_P1_NO_HANDSHAKE] <= 1'b0;
            end
        end
    end

    // Legacy profile bits, one per profile
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1)
        begin : g_legacy
            localparam [31:0] LEGACY_CODE = `CPPS_PROF_LEGACY_BASE + gi;
            assign legacy_hit[gi] = profile_accepted &&
                (profile_code == LEGACY_CODE[3:0]);
            always @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                    legacy[gi] <= 1'b0;
                else if (clear_all)
                    legacy[gi] <= 1'b0;
                else if (legacy_hit[gi])
                    legacy[gi] <= 1'b1;
            end
        end
    endgenerate

    // Unimplemented top bit of the legacy register
    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            legacy[7] <= 1'b0;
        else
            legacy[7] <= 1'b0;
    end

    // ****************************************************************
    // Switch steering, independent of alert and attach logic
    // ****************************************************************
    always @*
    begin
        next_switch = 1'b0;
        next_limit  = `CPPS_LIMIT_TRIP;
        if (|legacy[6:0])
        begin
            next_switch = dedicated_charger_switch_close;
            next_limit  = custom_limit_mode;
        end
        else if (profile_one[`CPPS_P1_CUSTOM])
        begin
            next_switch = custom_switch_close;
            next_limit  = custom_limit_mode;
        end
        else if (profile_one[`CPPS_P1_DCP])
        begin
            next_switch = dedicated_charger_switch_close;
            next_limit  = `CPPS_LIMIT_CONSTANT;
        end
        else if (profile_one[`CPPS_P1_CDP] || profile_one[`CPPS_P1_PASSTHRU])
        begin
            next_switch = 1'b1;
            next_limit  = `CPPS_LIMIT_TRIP;
        end
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            data_switch_close <= 1'b0;
            limit_mode        <= `CPPS_LIMIT_TRIP;
        end
        else
        begin
            data_switch_close <= next_switch;
            limit_mode        <= next_limit;
        end
    end

    // ****************************************************************
    // Read port, no side effects
    // ****************************************************************
    always @*
    begin
        next_read_data = `CPPS_RESET_BYTE;
        case (read_addr)
            `CPPS_ADDR_PROFILE_ONE: next_read_data = profile_one;
            `CPPS_ADDR_LEGACY:      next_read_data = legacy;
            `CPPS_ADDR_PIN_STATE:
            begin
                next_read_data[`CPPS_PIN_PORT_POWER_ENABLE] = pw_en_eff;
                next_read_data[`CPPS_PIN_MODE2]  = m2_eff;
                next_read_data[`CPPS_PIN_MODE1]  = m1_eff;
                next_read_data[`CPPS_PIN_EMUL]   = em_eff;
                next_read_data[`CPPS_PIN_POLARITY] = polarity;
                // Access wakes the part, sleep code never returned
                next_read_data[1:0] = (power_state == `CPPS_STATE_SLEEP) ?
                                      `CPPS_STATE_DETECT : power_state;
            end
            default: next_read_data = `CPPS_RESET_BYTE;
        endcase
    end

    always @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            read_data    <= `CPPS_RESET_BYTE;
            wake_request <= 1'b0;
        end
        else
        begin
            read_data    <= next_read_data;
            wake_request <= host_access;
        end
    end

endmodule

`default_nettype wire

// ### tb/cpps_status_props.sv
// Concurrent checks on the status bank ports
`timescale 1ns/1ns
`default_nettype none
module cpps_status_props
(
    // Clock and reset
    input wire       ref_clk,
    input wire       rst_b,
    // Inputs watched
    input wire       profile_accepted,
    input wire [3:0] profile_code,
    input wire       removal_event,
    input wire       new_active_mode,
    input wire       dedicated_charger_switch_close,
    input wire [1:0] custom_limit_mode,
    input wire       host_access,
    input wire [7:0] read_addr,
    // Outputs watched
    input wire [7:0] read_data,
    input wire       wake_request,
    input wire       data_switch_close,
    input wire [1:0] limit_mode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Clear events that win over a set
    wire clr = removal_event | new_active_mode;

    wake_on_access_a: assert property (
        host_access |=> wake_request) else $error("no wake after access");
    legacy_top_a: assert property (
        read_addr == 8'h13 |=> !read_data[7]) else $error("legacy bit 7 set");
    never_sleep_a: assert property (
        read_addr == 8'h14 |=> !read_data[7] && read_data[1:0] != 2'h0)
        else $error("pin status shows sleep");
    handshake_missing_flag_alone_a: assert property (
        read_addr == 8'h12 |=> !(read_data[7] && read_data[3:0] != 4'h0))
        else $error("no handshake with profile");
    legacy_clear_a: assert property (
        clr ##1 read_addr == 8'h13 |=> read_data[6:0] == 7'h0)
        else $error("legacy bits kept");
    profile_clear_a: assert property (
        clr ##1 read_addr == 8'h12 |=> read_data[3:1] == 3'h0)
        else $error("profile bits kept");
    cdp_steer_a: assert property (
        profile_accepted && profile_code == 4'h1 && !clr
        |-> ##[1:4] data_switch_close && limit_mode == 2'h0) else $error("cdp steer");
    dcp_steer_a: assert property (
        profile_accepted && profile_code == 4'h2 && !clr |-> ##[1:4]
        limit_mode == 2'h1 && data_switch_close == dedicated_charger_switch_close)
        else $error("dcp steer");
    legacy_steer_a: assert property (
        profile_accepted && profile_code[3] && profile_code != 4'hF && !clr
        |-> ##[1:4] data_switch_close == dedicated_charger_switch_close
        && limit_mode == custom_limit_mode) else $error("legacy steer");
endmodule

bind cpps_status cpps_status_props u_props
(
    .ref_clk, .rst_b, .profile_accepted, .profile_code, .removal_event,
    .new_active_mode, .dedicated_charger_switch_close, .custom_limit_mode,
    .host_access, .read_addr, .read_data, .wake_request, .data_switch_close,
    .limit_mode
);
`default_nettype wire

// ### tb/cpps_portable_dev.sv
// Portable device model driving handshake events
`timescale 1ns/1ns
`default_nettype none
module cpps_portable_dev
(
    // Clock
    input  wire        ref_clk,
    // Handshake events
    output logic       profile_accepted,
    output logic [3:0] profile_code,
    output logic       profile_ended_no_handshake,
    output logic       profile_applied,
    output logic       removal_event
);
    // Idle levels
    initial
    begin
        {profile_accepted, profile_ended_no_handshake} = 2'h0;
        {profile_applied, removal_event} = 2'h0;
        profile_code = 4'hF;
    end
    // Accept profile c; the code bus is scrambled outside the pulse
    task accept(input logic [3:0] c);
    begin
        @(negedge ref_clk);
        profile_code = c;
        profile_accepted = 1'b1;
        @(negedge ref_clk);
        profile_accepted = 1'b0;
        profile_code = ~c;
    end
    endtask
    // A profile is applied and the device ignores it
    task handshake_missing_flag;
    begin
        @(negedge ref_clk);
        profile_applied = 1'b1;
        @(negedge ref_clk);
        profile_applied = 1'b0;
        repeat (2) @(negedge ref_clk);
        profile_ended_no_handshake = 1'b1;
        @(negedge ref_clk);
        profile_ended_no_handshake = 1'b0;
    end
    endtask
    // Device unplugged
    task remove;
    begin
        @(negedge ref_clk);
        removal_event = 1'b1;
        @(negedge ref_clk);
        removal_event = 1'b0;
    end
    endtask
endmodule
`default_nettype wire

// ### tb/cpps_tb_top.sv
// Self-checking bench for the status bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // Signals named after the ports
    logic       ref_clk, rst_b, host_access, wake_request, data_switch_close;
    logic       port_power_enable_pin, mode_select_first_pin, mode_select_second_pin;
    logic       emulation_enable_pin, polarity_select_pin, source_undervoltage_pin;
    logic       override_enable, port_power_enable_set, mode_select_first_set;
    logic       mode_select_second_set, emulation_enable_set, custom_switch_close;
    logic       dedicated_charger_switch_close, passthrough_mode, new_active_mode;
    logic       profile_accepted, profile_ended_no_handshake, profile_applied, removal_event;
    logic [1:0] custom_limit_mode, power_state, limit_mode;
    logic [3:0] profile_code;
    logic [7:0] read_addr, read_data;
    int         fails, n_tests;

    // Design and device model
    cpps_status dut
    (
        .ref_clk, .rst_b, .port_power_enable_pin, .mode_select_first_pin,
        .mode_select_second_pin, .emulation_enable_pin, .polarity_select_pin,
        .source_undervoltage_pin, .override_enable, .port_power_enable_set,
        .mode_select_first_set, .mode_select_second_set, .emulation_enable_set,
        .dedicated_charger_switch_close, .custom_switch_close, .custom_limit_mode,
        .passthrough_mode, .profile_accepted, .profile_code, .profile_ended_no_handshake,
        .profile_applied, .removal_event, .new_active_mode, .power_state, .host_access,
        .read_addr, .read_data, .wake_request, .data_switch_close, .limit_mode
    );
    cpps_portable_dev dev
    (
        .ref_clk, .profile_accepted, .profile_code, .profile_ended_no_handshake,
        .profile_applied, .removal_event
    );

    // 20 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Host read, masked compare one cycle later
    task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    begin
        @(negedge ref_clk);
        read_addr = a;
        host_access = 1'b1;
        @(negedge ref_clk);
        host_access = 1'b0;
        chk("read_data", read_data & m, exp);
        chk("wake_request", {7'h0, wake_request}, 8'h01);
    end
    endtask
    // Switch steering once the outputs have settled
    task steer(input logic sw, input logic [1:0] lim);
    begin
        w(3);
        chk("data_switch_close", {7'h0, data_switch_close}, {7'h0, sw});
        chk("limit_mode", {6'h0, limit_mode}, {6'h0, lim});
    end
    endtask
    task new_mode;
    begin
        @(negedge ref_clk);
        new_active_mode = 1'b1;
        @(negedge ref_clk);
        new_active_mode = 1'b0;
    end
    endtask
    task tally_and_finish;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // Hang guard
    initial
    begin
        #2000000;
        fails++;
        tally_and_finish;
    end

    // Test sequence
    initial
    begin
        {rst_b, host_access, read_addr, override_enable, port_power_enable_set} = '0;
        {mode_select_first_set, mode_select_second_set, emulation_enable_set} = '0;
        {custom_switch_close, passthrough_mode, new_active_mode, mode_select_first_pin} = '0;
        {source_undervoltage_pin, dedicated_charger_switch_close} = '0;
        {port_power_enable_pin, mode_select_second_pin, emulation_enable_pin} = 3'h7;
        polarity_select_pin = 1'b1;
        custom_limit_mode = 2'h2;
        power_state = 2'h2;
        fails = 0;
        n_tests = 0;
        w(16);
        rst_b = 1'b1;
        w(3);
        rd(8'h12, 8'hFF, 8'h00);
        rd(8'h13, 8'hFF, 8'h00);
        rd(8'h14, 8'hFF, 8'h6E);
        rd(8'h15, 8'hFF, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            power_state = s[1:0];
            w(2);
            rd(8'h14, 8'h03, (s == 0) ? 8'h01 : 8'(s));
        end
        power_state = 2'h2;
        $display("done reset and pins");
        dev.accept(4'h1);
        rd(8'h12, 8'hFF, 8'h02);
        steer(1'b1, 2'h0);
        dev.handshake_missing_flag();
        rd(8'h12, 8'hFF, 8'h02);
        dev.remove();
        rd(8'h12, 8'hFF, 8'h00);
        dev.handshake_missing_flag();
        rd(8'h12, 8'hFF, 8'h80);
        dev.accept(4'h2);
        rd(8'h12, 8'hFF, 8'h04);
        steer(1'b0, 2'h1);
        new_mode();
        rd(8'h12, 8'hFF, 8'h00);
        dev.accept(4'h3);
        rd(8'h12, 8'hFF, 8'h08);
        dev.remove();
        rd(8'h12, 8'hFF, 8'h00);
        $display("done cdp dcp");
        for (int k = 0; k < 7; k++)
        begin
            dedicated_charger_switch_close = k[0];
            dev.accept(4'h8 + 4'(k));
            rd(8'h13, 8'hFF, 8'h01 << k);
            steer(k[0], 2'h2);
            case (k % 3)
                0: dev.remove();
                1: new_mode();
                default: port_power_enable_pin = 1'b0;
            endcase
            w(5);
            rd(8'h13, 8'hFF, 8'h00);
            port_power_enable_pin = 1'b1;
            w(5);
        end
        $display("done legacy");
        passthrough_mode = 1'b1;
        w(2);
        rd(8'h12, 8'hFF, 8'h01);
        steer(1'b1, 2'h0);
        dev.remove();
        rd(8'h12, 8'hFF, 8'h00);
        w(4);
        rd(8'h12, 8'hFF, 8'h00);
        mode_select_first_pin = 1'b1;
        w(5);
        rd(8'h12, 8'hFF, 8'h01);
        passthrough_mode = 1'b0;
        w(2);
        rd(8'h12, 8'hFF, 8'h00);
        source_undervoltage_pin = 1'b1;
        w(4);
        rd(8'h12, 8'h10, 8'h10);
        source_undervoltage_pin = 1'b0;
        w(4);
        rd(8'h12, 8'h10, 8'h00);
        $display("done passthrough");
        override_enable = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            {port_power_enable_set, mode_select_second_set, mode_select_first_set,
             emulation_enable_set} = 4'h1 << i;
            w(4);
            rd(8'h14, 8'h78, 8'h08 << i);
        end
        rst_b = 1'b0;
        polarity_select_pin = 1'b0;
        w(3);
        rst_b = 1'b1;
        w(4);
        rd(8'h14, 8'h04, 8'h00);
        $display("done override and polarity");
        tally_and_finish;
    end
endmodule
`default_nettype wire
